// *** shared/lca_pkg.sv ***
// Package of constants and types for the arithmetic carry-select logic cell
package lca_pkg;

	// Register map, byte addresses on the Avalon-MM slave
	localparam logic [3:0] LCA_ADDR_CONFIG = 4'h0;
	localparam logic [3:0] LCA_ADDR_STATUS = 4'h4;

	// Field positions inside the configuration word
	localparam int LCA_CFG_MODE_BIT = 0;
	localparam int LCA_CFG_LUT_CARRY_BIT = 1;
	localparam int LCA_CFG_CHAIN_START_BIT = 2;
	localparam int LCA_CFG_CHAIN_END_BIT = 3;
	localparam int LCA_CFG_COUNTER_BIT = 4;
	localparam int LCA_CFG_PACK_BIT = 5;
	localparam int LCA_CFG_REG_CHAIN_BIT = 6;
	localparam int LCA_CFG_LUT_CHAIN_BIT = 7;
	localparam int LCA_CFG_PRESET_BIT = 8;
	localparam int LCA_CFG_CLK_SEL_BIT = 9;
	localparam int LCA_CFG_ACLR_SEL_BIT = 10;
	localparam int LCA_CFG_DEV_CLR_BIT = 11;
	localparam int LCA_CFG_MASK_LSB = 16;

	// Values after reset
	localparam logic [31:0] LCA_CONFIG_RESET = 32'h0000_0000;
	localparam logic [31:0] LCA_READ_ZERO = 32'h0000_0000;

	// Carry generation points inside a ten-cell cluster
	localparam int LCA_CELLS_PER_CLUSTER = 10;
	localparam int LCA_GEN_POINT_LOW = 5;
	localparam int LCA_GEN_POINT_HIGH = 10;

	// Operating modes of the cell
	typedef enum logic {
		LCA_MODE_LOOKUP = 1'b0,
		LCA_MODE_ARITH = 1'b1
	} lca_mode_e;

	// Decoded configuration
	typedef struct packed {
		logic [15:0] lut_mask;
		logic dev_clr_en;
		logic aclr_sel;
		logic clk_sel;
		logic preset_mode;
		logic lut_chain_sel;
		logic reg_chain_sel;
		logic pack;
		logic counter;
		logic chain_end;
		logic chain_start;
		logic lut_carry;
		lca_mode_e mode;
	} lca_cfg_s;

	// Cluster-wide register controls and the add/subtract select
	typedef struct packed {
		logic ena0;
		logic ena1;
		logic aclr0;
		logic aclr1;
		logic aload;
		logic sclr;
		logic sload;
		logic addnsub;
	} lca_ctrl_s;

endpackage

// *** src/lca_logic_cell.sv ***
// Programmable logic cell with lookup and carry-select arithmetic modes
//
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
// Function
// RULE1: Cell runs in exactly one mode, lookup or dynamic arithmetic.
// RULE2: Cell takes four data inputs, two carries, cluster carry and chain input.
// RULE3: Cluster-wide lines give clock, enable, clears, preset/load, sync clear and load.
// RULE4: Add/subtract select acts only while the cell is in arithmetic mode.
// RULE5: Lookup mode feeds a four-input table; carry or fourth input is one input.
// RULE6: Lookup output may feed the next cell; register may hold unrelated logic.
// RULE7: Asynchronous load value comes from the fourth data input.
// RULE8: Carry reaches the lookup table only in a cell ending an adder chain.
// RULE9: Arithmetic mode makes two sums and two carry-outs for assumed carry 0 and 1.
// RULE10: Cluster carry picks a chain; that chain's level picks the sum.
// RULE11: Zero-assumed carry in selects zero-assumed carry out; same for one.
// RULE12: Arithmetic cell drives both registered and unregistered results.
// RULE13: Counter enable and up/down come from local data inputs.
// RULE14: Synchronous clear and load act on every register of the cluster.
// RULE15: Add/subtract select feeds the carry only of a chain's first cell.
// RULE16: Both carries of a lower bit feed the table and the next chain stage.
// RULE17: A carry-select chain may start at any cell of the cluster.
// RULE18: Cluster carry is generated only at cells five and ten.
// RULE19: Chains longer than ten cells continue into the next cluster.
// RULE20: Preset loads a high asynchronously; clear wins over preset/load.
// RULE21: Cluster offers two asynchronous clears and one preset line.
// RULE22: Optional active-low device-wide clear overrides every other control.
// RULE23: Subtraction inverts the second operand and forces first carry to one.
// RULE24: Each clock has its own enable; low enable stops those registers.
// RULE25: Counter with enable low and no sync clear or load holds its value.
module lca_logic_cell
	import lca_pkg::*;
#(
	parameter int CELL_INDEX = 1,
	parameter int ADDR_W = 4
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic [ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic [3:0] DATA_IN,
	input wire logic CARRY_ASSUME_ZERO_IN,
	input wire logic CARRY_ASSUME_ONE_IN,
	input wire logic CLUSTER_CARRY_IN,
	input wire logic REG_CHAIN_IN,
	input wire logic LUT_CHAIN_IN,
	input wire lca_ctrl_s CLUSTER_CTRL,
	input wire logic DEVICE_WIDE_CLEAR_N,
	output logic COMB_OUT,
	output logic REG_OUT,
	output logic REG_CHAIN_OUT,
	output logic LUT_CHAIN_OUT,
	output logic CARRY_ASSUME_ZERO_OUT,
	output logic CARRY_ASSUME_ONE_OUT,
	output logic CLUSTER_CARRY_OUT
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [31:0] config_reg;
	logic [31:0] readdata_reg;
	logic waitreq_reg;
	logic q_reg;
	logic q_next;
	lca_cfg_s cfg;
	logic arith;
	logic fourth_lut_input;
	logic op_a;
	logic op_b;
	logic sum_assume_zero;
	logic sum_assume_one;
	logic cout_assume_zero;
	logic cout_assume_one;
	logic chain_zero_in;
	logic chain_one_in;
	logic chain_sel;
	logic arith_sum;
	logic lut_in2;
	logic lut_in3;
	logic lut_out;
	logic cnt_ena;
	logic up_dn;
	logic clk_ena;
	logic ce_eff;
	logic aload_val;
	logic async_clr;
	logic async_set;
	logic bus_req;
	logic bus_take;

	localparam bit GEN_POINT = (CELL_INDEX == LCA_GEN_POINT_LOW) ||
		(CELL_INDEX == LCA_GEN_POINT_HIGH);

	////////////////////////////////////////////////////////////////////////////
	// Byte-lane merge, used for every writable register
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: one wait state, then the access completes

	assign bus_req = AVS_READ || AVS_WRITE;
	assign bus_take = bus_req && !waitreq_reg;

	// Waitrequest idles high and drops for exactly one cycle per access
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			waitreq_reg <= 1'b1;
		end else if (CE) begin
			waitreq_reg <= !(bus_req && waitreq_reg);
		end
	end

	// Read data is captured during the wait state so it stands at completion
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			readdata_reg <= LCA_READ_ZERO;
		end else if (CE && AVS_READ && waitreq_reg) begin
			unique case (AVS_ADDRESS)
				LCA_ADDR_CONFIG: readdata_reg <= config_reg;
				LCA_ADDR_STATUS: readdata_reg <= {26'h000_0000, CLUSTER_CARRY_OUT,
					CARRY_ASSUME_ONE_OUT, CARRY_ASSUME_ZERO_OUT, LUT_CHAIN_OUT,
					COMB_OUT, q_reg};
				default: readdata_reg <= LCA_READ_ZERO; // Unmapped reads as zero
			endcase
		end
	end

	// Configuration word; writes elsewhere are dropped silently
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			config_reg <= LCA_CONFIG_RESET;
		end else if (CE && bus_take && AVS_WRITE && AVS_ADDRESS == LCA_ADDR_CONFIG) begin
			config_reg <= lane_merge(config_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
		end
	end

	assign AVS_READDATA = readdata_reg;
	assign AVS_WAITREQUEST = waitreq_reg;

	////////////////////////////////////////////////////////////////////////////
	// Configuration decode
	always_comb begin
		cfg.mode = config_reg[LCA_CFG_MODE_BIT] ? LCA_MODE_ARITH : LCA_MODE_LOOKUP; // RULE1
		cfg.lut_carry = config_reg[LCA_CFG_LUT_CARRY_BIT];
		cfg.chain_start = config_reg[LCA_CFG_CHAIN_START_BIT];
		cfg.chain_end = config_reg[LCA_CFG_CHAIN_END_BIT];
		cfg.counter = config_reg[LCA_CFG_COUNTER_BIT];
		cfg.pack = config_reg[LCA_CFG_PACK_BIT];
		cfg.reg_chain_sel = config_reg[LCA_CFG_REG_CHAIN_BIT];
		cfg.lut_chain_sel = config_reg[LCA_CFG_LUT_CHAIN_BIT];
		cfg.preset_mode = config_reg[LCA_CFG_PRESET_BIT];
		cfg.clk_sel = config_reg[LCA_CFG_CLK_SEL_BIT];
		cfg.aclr_sel = config_reg[LCA_CFG_ACLR_SEL_BIT];
		cfg.dev_clr_en = config_reg[LCA_CFG_DEV_CLR_BIT];
		cfg.lut_mask = config_reg[LCA_CFG_MASK_LSB +: 16];
	end

	assign arith = (cfg.mode == LCA_MODE_ARITH);
	assign fourth_lut_input = DATA_IN[3]; // RULE2

	////////////////////////////////////////////////////////////////////////////
	// Arithmetic datapath: counter controls from local data inputs
	assign cnt_ena = DATA_IN[0]; // RULE13
	assign up_dn = DATA_IN[3]; // RULE13

	// Counter adds minus one to count down, plus carry to count up
	assign op_a = cfg.counter ? q_reg : DATA_IN[1];
	assign op_b = cfg.counter ? !up_dn : (DATA_IN[2] ^ (arith && CLUSTER_CTRL.addnsub)); // RULE23 RULE4

	// Two sums and two carry-outs for an assumed carry of zero and one
	assign sum_assume_zero = op_a ^ op_b; // RULE9
	assign sum_assume_one = !(op_a ^ op_b); // RULE9
	assign cout_assume_zero = op_a & op_b; // RULE9
	assign cout_assume_one = op_a | op_b; // RULE9

	// First cell of a chain takes its carry from add/subtract, or from up/down in a counter, else from below;
	// a lookup cell never starts a chain, so add/subtract cannot reach its table
	always_comb begin
		if (cfg.chain_start && arith) begin // RULE4
			chain_zero_in = cfg.counter ? up_dn : CLUSTER_CTRL.addnsub; // RULE15 RULE17 RULE23
			chain_one_in = cfg.counter ? up_dn : CLUSTER_CTRL.addnsub; // RULE15 RULE17 RULE23
		end else begin
			chain_zero_in = CARRY_ASSUME_ZERO_IN; // RULE16
			chain_one_in = CARRY_ASSUME_ONE_IN; // RULE16
		end
	end

	// Cluster carry picks the chain; its level then picks the sum
	assign chain_sel = CLUSTER_CARRY_IN ? chain_one_in : chain_zero_in; // RULE10 RULE19
	assign arith_sum = chain_sel ? sum_assume_one : sum_assume_zero; // RULE10

	// Each chain's own carry selects its own carry-out
	assign CARRY_ASSUME_ZERO_OUT = chain_zero_in ? cout_assume_one : cout_assume_zero; // RULE11
	assign CARRY_ASSUME_ONE_OUT = chain_one_in ? cout_assume_one : cout_assume_zero; // RULE11 RULE16

	// Only the generation points drive the cluster carry, keeping the path short
	assign CLUSTER_CARRY_OUT = GEN_POINT && arith &&
		(CLUSTER_CARRY_IN ? CARRY_ASSUME_ONE_OUT : CARRY_ASSUME_ZERO_OUT); // RULE18 RULE19

	////////////////////////////////////////////////////////////////////////////
	// Lookup datapath
	assign lut_in2 = cfg.lut_chain_sel ? LUT_CHAIN_IN : DATA_IN[2]; // RULE6
	// Carry enters the table only when this cell closes an adder chain
	assign lut_in3 = (cfg.lut_carry && cfg.chain_end) ? chain_sel : fourth_lut_input; // RULE5 RULE8
	assign lut_out = cfg.lut_mask[{lut_in3, lut_in2, DATA_IN[1], DATA_IN[0]}]; // RULE5

	// Unregistered result, plus the fast path to the cell below
	assign COMB_OUT = arith ? arith_sum : lut_out; // RULE1 RULE12
	assign LUT_CHAIN_OUT = lut_out; // RULE6

	////////////////////////////////////////////////////////////////////////////
	// Register controls
	assign clk_ena = cfg.clk_sel ? CLUSTER_CTRL.ena1 : CLUSTER_CTRL.ena0; // RULE24
	assign ce_eff = CE && clk_ena; // RULE24 RULE3

	// Preset is an asynchronous load of a high
	assign aload_val = cfg.preset_mode ? 1'b1 : fourth_lut_input; // RULE7 RULE20

	// Clear terms dominate; load of a low is a clear, load of a high a set
	assign async_clr = !RST_N || (cfg.dev_clr_en && !DEVICE_WIDE_CLEAR_N) || // RULE22
		(cfg.aclr_sel ? CLUSTER_CTRL.aclr1 : CLUSTER_CTRL.aclr0) || // RULE21
		(CLUSTER_CTRL.aload && !aload_val); // RULE7
	assign async_set = CLUSTER_CTRL.aload && aload_val && !async_clr; // RULE20

	// Synchronous next value; packing lets the register hold unrelated data
	always_comb begin
		if (CLUSTER_CTRL.sclr) begin
			q_next = 1'b0; // RULE14
		end else if (CLUSTER_CTRL.sload) begin
			q_next = fourth_lut_input; // RULE14
		end else if (cfg.reg_chain_sel) begin
			q_next = REG_CHAIN_IN;
		end else if (cfg.pack) begin
			q_next = fourth_lut_input; // RULE6
		end else if (arith && cfg.counter && !cnt_ena) begin
			q_next = q_reg; // RULE25
		end else begin
			q_next = COMB_OUT; // RULE12
		end
	end

	// Asynchronous terms only ever force constants into the flop
	always_ff @(posedge CLK or posedge async_clr or posedge async_set) begin
		if (async_clr) begin
			q_reg <= 1'b0; // RULE20 RULE22
		end else if (async_set) begin
			q_reg <= 1'b1; // RULE20
		end else if (ce_eff) begin
			q_reg <= q_next; // RULE3
		end
	end

	assign REG_OUT = q_reg;
	assign REG_CHAIN_OUT = q_reg;

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	// Edge with no asynchronous term acting on the cell register
	sequence s_quiet_edge;
		!async_clr && !async_set;
	endsequence

	// Enabled edge that applies a synchronous clear
	sequence s_sclr_edge;
		ce_eff && CLUSTER_CTRL.sclr && !async_clr && !async_set;
	endsequence

	// Enabled edge that applies a synchronous load; clear has priority
	sequence s_sload_edge;
		ce_eff && !CLUSTER_CTRL.sclr && CLUSTER_CTRL.sload && !async_clr && !async_set;
	endsequence

	// Enabled edge on which a counter with its enable low must keep its count
	sequence s_hold_edge;
		(ce_eff && arith && cfg.counter && !cnt_ena && !CLUSTER_CTRL.sclr &&
			!CLUSTER_CTRL.sload && !cfg.reg_chain_sel && !cfg.pack) and s_quiet_edge;
	endsequence

	// Edge on which the register clock is gated off
	sequence s_frozen_edge;
		!ce_eff and s_quiet_edge;
	endsequence

	// Asynchronous terms; clear has to beat preset and load
	a_clear_wins: assert property (async_clr |-> !REG_OUT) // RULE20
		else $error("Register not clear while a clear is active");
	a_preset_high: assert property ( // RULE20
		CLUSTER_CTRL.aload && cfg.preset_mode && !async_clr |-> REG_OUT)
		else $error("Preset did not hold register high");
	a_async_load: assert property ( // RULE7
		CLUSTER_CTRL.aload && !cfg.preset_mode && !(cfg.dev_clr_en && !DEVICE_WIDE_CLEAR_N) &&
		!(cfg.aclr_sel ? CLUSTER_CTRL.aclr1 : CLUSTER_CTRL.aclr0) |-> REG_OUT == DATA_IN[3])
		else $error("Asynchronous load did not copy the fourth data input");
	a_dev_clear: assert property ( // RULE22
		cfg.dev_clr_en && !DEVICE_WIDE_CLEAR_N |-> !REG_OUT)
		else $error("Device-wide clear did not clear the register");

	// Synchronous controls, looked at one edge after they act
	a_sclr_zero: assert property (s_sclr_edge ##1 s_quiet_edge |-> !REG_OUT) // RULE14
		else $error("Synchronous clear left register set");
	a_sload_data: assert property ( // RULE14
		s_sload_edge ##1 s_quiet_edge |-> REG_OUT == $past(DATA_IN[3]))
		else $error("Synchronous load did not take the fourth data input");
	a_counter_hold: assert property (s_hold_edge ##1 s_quiet_edge |-> $stable(REG_OUT)) // RULE25
		else $error("Disabled counter changed value");
	a_enable_freeze: assert property ( // RULE24
		s_frozen_edge ##1 s_quiet_edge |-> $stable(REG_OUT))
		else $error("Register moved with clock enable low");

	// Datapath: selected sum, carries of each chain, cluster carry
	a_sum_select: assert property (arith |-> COMB_OUT == (op_a ^ op_b ^ chain_sel)) // RULE10
		else $error("Arithmetic output is not the selected sum");
	a_carry_zero: assert property ( // RULE11
		arith |-> CARRY_ASSUME_ZERO_OUT == ((op_a && op_b) || (chain_zero_in && (op_a ^ op_b))))
		else $error("Zero-assumed carry-out does not follow its own carry-in");
	a_carry_one: assert property ( // RULE11
		arith |-> CARRY_ASSUME_ONE_OUT == ((op_a && op_b) || (chain_one_in && (op_a ^ op_b))))
		else $error("One-assumed carry-out does not follow its own carry-in");
	a_carry_points: assert property (!GEN_POINT |-> !CLUSTER_CARRY_OUT) // RULE18
		else $error("Cluster carry driven off a generation point");
	a_sub_carry: assert property ( // RULE23
		cfg.chain_start && !cfg.counter && arith && CLUSTER_CTRL.addnsub |->
		chain_sel && (op_b != DATA_IN[2]))
		else $error("Subtract did not invert operand and force carry");

	// Lookup mode: add/subtract and chain start must not reach the table
	a_lookup_only: assert property ( // RULE4
		!arith && !cfg.counter |-> op_b == DATA_IN[2] &&
		chain_sel == (CLUSTER_CARRY_IN ? CARRY_ASSUME_ONE_IN : CARRY_ASSUME_ZERO_IN))
		else $error("Add/subtract touched a lookup-mode cell");
	a_lut_chain: assert property (!arith |-> COMB_OUT == LUT_CHAIN_OUT) // RULE6
		else $error("Lookup chain output differs from the table output");

	// Bus handshake: exactly one wait state per access
	a_wait_pulse: assert property ( // RULE3
		bus_req && AVS_WAITREQUEST && CE |=> !AVS_WAITREQUEST ##1 (AVS_WAITREQUEST || !CE))
		else $error("Waitrequest did not drop for one cycle");

endmodule

// *** dv/lca_nbr_model.sv ***
// Model of the lower neighbouring logic cell feeding carries and chains
`timescale 1ns/10ps
module lca_nbr_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic na,
	input wire logic nb,
	input wire logic nd,
	output logic carry0,
	output logic carry1,
	output logic reg_chain,
	output logic lut_chain
);
	// Both assumed-carry outputs of a one-bit add move forward together
	assign carry0 = na & nb;
	assign carry1 = na | nb;
	// Table output handed straight down the lookup chain
	assign lut_chain = na ^ nb;
	// Own register shifted into the next cell's register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_chain <= 1'b0;
		end else begin
			reg_chain <= nd;
		end
	end
endmodule

// *** dv/logic_cell_arith_carry_select_tb.sv ***
// Self-checking bench for one logic cell against a behavioural model
`timescale 1ns/10ps
module logic_cell_arith_carry_select_tb;
	import lca_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic [3:0] addr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0000_0000;
	logic [3:0] be = 4'hF;
	logic [3:0] din = 4'h0;
	logic na = 1'b0;
	logic nb = 1'b0;
	logic nd = 1'b0;
	logic cci = 1'b0;
	logic dclr_n = 1'b1;
	lca_ctrl_s ctrl = '0;
	logic [31:0] rdat, cfg_m, r, c, rv, sm;
	logic wreq, c0i, c1i, rci, lci, comb, q, qc, lco, c0o, c1o, cco;
	logic q_m, nd_q;
	int miscompares = 0;
	int n_compared = 0;
	// Reference of the async terms; clear beats load
	wire aclr = (cfg_m[10] ? ctrl.aclr1 : ctrl.aclr0) | (cfg_m[11] & !dclr_n);
	wire aforce = aclr | ctrl.aload;
	wire aval = !aclr & (cfg_m[8] | din[3]);
	wire eq = aforce ? aval : q_m;
	wire en = ce & (cfg_m[9] ? ctrl.ena1 : ctrl.ena0);

	always #50 clk = ~clk;
	lca_logic_cell lca_logic_cell_i (.CLK(clk), .RST_N(rst_n), .CE(ce), .AVS_ADDRESS(addr),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be),
		.AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .DATA_IN(din),
		.CARRY_ASSUME_ZERO_IN(c0i), .CARRY_ASSUME_ONE_IN(c1i), .CLUSTER_CARRY_IN(cci),
		.REG_CHAIN_IN(rci), .LUT_CHAIN_IN(lci), .CLUSTER_CTRL(ctrl),
		.DEVICE_WIDE_CLEAR_N(dclr_n), .COMB_OUT(comb), .REG_OUT(q), .REG_CHAIN_OUT(qc),
		.LUT_CHAIN_OUT(lco), .CARRY_ASSUME_ZERO_OUT(c0o), .CARRY_ASSUME_ONE_OUT(c1o),
		.CLUSTER_CARRY_OUT(cco));
	lca_nbr_model lca_nbr_model_i (.clk(clk), .rst_n(rst_n), .na(na), .nb(nb), .nd(nd),
		.carry0(c0i), .carry1(c1i), .reg_chain(rci), .lut_chain(lci));

	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	// Expected {cluster carry, carry1, carry0, chain, comb} for present inputs
	function automatic logic [4:0] ecomb();
		logic i2, i3, a, b, k0, k1, t;
		i2 = cfg_m[7] ? (na ^ nb) : din[2];
		i3 = (cfg_m[1] & cfg_m[3]) ? na : din[3];
		t = cfg_m[16 + {i3, i2, din[1:0]}];
		a = cfg_m[4] ? eq : din[1];
		b = (cfg_m[4] ? !din[3] : din[2]) ^ ctrl.addnsub;
		k0 = cfg_m[2] ? (cfg_m[4] ? din[3] : ctrl.addnsub) : (na & nb);
		k1 = cfg_m[2] ? (cfg_m[4] ? din[3] : ctrl.addnsub) : (na | nb);
		if (!cfg_m[0])
			return {3'b000, t, t};
		return {1'b0, (a & b) | (k1 & (a ^ b)), (a & b) | (k0 & (a ^ b)), 1'b0,
			a ^ b ^ (cci ? k1 : k0)};
	endfunction
	// Next register value by sync priority
	function automatic logic nxt();
		logic [4:0] e;
		e = ecomb();
		if (ctrl.sclr) return 1'b0;
		if (ctrl.sload) return din[3];
		if (cfg_m[6]) return nd_q;
		if (cfg_m[5]) return din[3];
		if (cfg_m[4] & !din[0]) return eq;
		return e[0];
	endfunction
	// Reference register and neighbour chain flop; config writes land by NBA too
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q_m <= 1'b0;
			nd_q <= 1'b0;
		end else begin
			nd_q <= nd;
			if (aforce)
				q_m <= aval;
			else if (en)
				q_m <= nxt();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t read %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_cell();
		logic [4:0] m;
		logic [6:0] g, e;
		m = cfg_m[0] ? 5'b1_1101 : 5'b0_0011;
		g = {qc, q, {cco, c1o, c0o, lco, comb} & m};
		e = {eq, eq, ecomb() & m};
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t cell outputs %b expected %b", $time, g, e);
		end
	endtask
	// One bus access; request held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] b, output logic [31:0] rr);
		logic [31:0] m;
		m = cfg_m;
		@(posedge clk);
		ce <= 1'b1;
		addr <= a;
		wd <= d;
		be <= b;
		rd <= !w;
		wr <= w;
		// No cycle count assumed; a hung slave is caught by the watchdog
		do begin
			@(posedge clk);
		end while (wreq !== 1'b0);
		rr = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		for (int i = 0; i < 4; i++)
			if (b[i]) m[8 * i +: 8] = d[8 * i +: 8];
		if (w && a == LCA_ADDR_CONFIG) cfg_m <= m;
	endtask
	task automatic report_and_stop();
		if (miscompares == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Watchdog well beyond the roughly one thousand cycles the run needs
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		report_and_stop();
	end
	// Register checks, then random traffic compared every cycle
	initial begin
		cfg_m = 32'h0000_0000;
		r = 32'h0000_6879;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		bus(1'b0, LCA_ADDR_CONFIG, 32'h0000_0000, 4'hF, rv);
		chk_rd(rv, LCA_CONFIG_RESET);
		bus(1'b1, LCA_ADDR_CONFIG, 32'hFFFF_FFFF, 4'b0001, rv);
		bus(1'b1, LCA_ADDR_STATUS, 32'hFFFF_FFFF, 4'hF, rv);
		bus(1'b1, 4'h8, 32'hFFFF_FFFF, 4'hF, rv);
		bus(1'b0, 4'h8, 32'h0000_0000, 4'hF, rv);
		chk_rd(rv, LCA_READ_ZERO);
		bus(1'b0, LCA_ADDR_CONFIG, 32'h0000_0000, 4'hF, rv);
		chk_rd(rv, 32'h0000_00FF);
		for (int it = 0; it < 400; it++) begin
			if (it % 8 == 0) begin
				r = xs(r);
				c = r & 32'hFFFF_0FFF;
				if (c[4]) c = c | 32'h0000_0005;
				@(posedge clk);
				ctrl <= '0;
				nb <= na;
				bus(1'b1, LCA_ADDR_CONFIG, c, 4'hF, rv);
				bus(1'b0, LCA_ADDR_CONFIG, 32'h0000_0000, 4'hF, rv);
				chk_rd(rv, c);
				bus(1'b0, LCA_ADDR_STATUS, 32'h0000_0000, 4'hF, rv);
				sm = cfg_m[0] ? 32'hFFFF_FFFB : 32'hFFFF_FFE7;
				chk_rd(rv & sm, {26'h0, ecomb(), eq} & sm);
			end
			@(posedge clk);
			r = xs(r);
			din <= r[3:0];
			na <= r[4];
			nb <= cfg_m[0] ? r[5] : r[4];
			nd <= r[6];
			cci <= r[7];
			ctrl <= '{r[8] | r[9], r[10] | r[11], &r[14:12], &r[17:15], &r[20:18],
				&r[23:21], &r[26:24], r[27] & !cfg_m[4]};
			dclr_n <= |r[30:28];
			ce <= r[31] | r[0] | r[5];
			#10;
			chk_cell();
		end
		report_and_stop();
	end
endmodule
